// ==== src/fpci_dev.sv ====
/*
  Flash protection device end: takes CPU cycles from the shared bus,
  keeps the protection register, temporary protection states, system
  configuration bits and the erase address window, and answers reads.
  Assumes the array behind it answers array_rdata combinationally.
*/
module fpci_dev
  import fpci_pkg::*;
#(
  parameter int ERASE_TMO_CYCLES = ERASE_TMO_CYC
) (
  fpci_if.dev bus,
  input wire logic external_access_n,
  output logic [23:0] array_addr,
  input wire logic [15:0] array_rdata,
  output logic [15:0] protection_register,
  output logic code_protect_active,
  output logic [14:0] block_protect,
  output logic [7:0] flash_status_byte,
  output logic internal_memory_enable,
  output logic low_segment_map_select,
  output logic segmentation_disable,
  output logic cpu_reset_extend
);
  logic take;
  logic wr;
  logic rd;
  logic strap_done;
  logic code_tmp_unprot;
  logic blk_tmp_unprot;
  logic write_error;
  logic [12:0] tmo_cnt;
  logic tmo_elapsed;
  logic [2:0] rst_cnt;
  logic hit;
  logic set_prot_wr;
  logic [15:0] set_prot_val;
  logic blk_unprot;
  logic read_prot_mode;
  logic in_seq;

  // True when an address falls in the flash as currently mapped.
  function automatic logic in_flash(
    input logic [23:0] a,
    input logic en,
    input logic lowmap,
    input logic segdis
  );
    logic low_hit;
    logic up_hit;
    low_hit = lowmap ? (a < LOW_BLK_SIZE) : (a >= LOW_BLK_SEG1 && a < UPPER_LO);
    up_hit = a >= UPPER_LO && a <= UPPER_HI;
    // With segmentation disabled only segment 0 is reachable.
    in_flash = en && (low_hit || up_hit) && !(segdis && a[23:16] != 8'h00);
  endfunction : in_flash

  // A request is taken on the edge where req is high and no answer stands.
  assign take = bus.req && !bus.ack;
  assign wr = take && bus.we;
  assign rd = take && !bus.we;
  assign array_addr = bus.addr;
  assign hit = in_flash(bus.addr, internal_memory_enable, low_segment_map_select, segmentation_disable);

  fpci_seq u_seq (
    .pclk(bus.pclk),
    .presetn(bus.presetn),
    .wr(wr),
    .addr(bus.addr),
    .wdata(bus.wdata),
    .set_prot_wr(set_prot_wr),
    .set_prot_val(set_prot_val),
    .blk_unprot(blk_unprot),
    .read_prot_mode(read_prot_mode),
    .in_seq(in_seq)
  );

  // One-cycle answer to every taken request.
  always_ff @(posedge bus.pclk or negedge bus.presetn) begin
    if (!bus.presetn) bus.ack <= 1'b0;
    else bus.ack <= take;
  end

  // Read data mux; dummy data inside a sequence keeps the array hidden.
  always_ff @(posedge bus.pclk or negedge bus.presetn) begin
    if (!bus.presetn) begin
      bus.rdata <= DUMMY_DATA;
    end else if (rd) begin
      if (in_seq) bus.rdata <= DUMMY_DATA;
      else if (read_prot_mode && bus.addr[1:0] == ODD_WORD_LSB) bus.rdata <= protection_register;
      else if (code_protect_active && !bus.from_flash && hit) bus.rdata <= TRAP_OPCODE;
      else bus.rdata <= array_rdata;
    end
  end

  // Protection register. A reset restores the erased value here because the
  // nonvolatile cell behind it is not modelled; a real part would keep it.
  // A new value may only clear bits, never raise one already cleared.
  always_ff @(posedge bus.pclk or negedge bus.presetn) begin
    if (!bus.presetn) begin
      protection_register <= PR_ERASED;
      write_error <= 1'b0;
    end else if (set_prot_wr) begin
      if ((set_prot_val & ~protection_register) != 16'h0000) begin
        write_error <= 1'b1;
      end else begin
        protection_register <= set_prot_val;
        write_error <= 1'b0;
      end
    end
  end

  // Code temporary unprotect and protect; both count only from flash code.
  always_ff @(posedge bus.pclk or negedge bus.presetn) begin
    if (!bus.presetn) begin
      code_tmp_unprot <= 1'b0;
    end else if (wr && bus.from_flash && hit) begin
      if (bus.wdata == D_CODE_UNPROT) code_tmp_unprot <= 1'b1;
      else if (bus.wdata == D_CODE_PROT && bus.absolute_mode) code_tmp_unprot <= 1'b0;
    end
  end

  // Block temporary unprotect lasts until the next system reset.
  always_ff @(posedge bus.pclk or negedge bus.presetn) begin
    if (!bus.presetn) blk_tmp_unprot <= 1'b0;
    else if (blk_unprot) blk_tmp_unprot <= 1'b1;
  end

  assign code_protect_active = !protection_register[CODE_PROT_BIT] && !code_tmp_unprot;
  assign block_protect = blk_tmp_unprot ? 15'h0000 : ~protection_register[14:0];

  // Erase address window: every block address written restarts it; when it
  // runs out the timeout flag rises and refuses block addresses until a write outside a sequence clears it.
  always_ff @(posedge bus.pclk or negedge bus.presetn) begin
    if (!bus.presetn) begin
      tmo_cnt <= 13'h0000;
      tmo_elapsed <= 1'b0;
    end else if (wr && hit && !in_seq && bus.wdata[7:0] == D_ERASE_BLOCK && (tmo_cnt != 13'h0000 || !tmo_elapsed)) begin
      tmo_cnt <= 13'(ERASE_TMO_CYCLES);
      tmo_elapsed <= 1'b0;
    end else if (tmo_cnt != 13'h0000) begin
      tmo_cnt <= tmo_cnt - 13'h0001;
      if (tmo_cnt == 13'h0001) tmo_elapsed <= 1'b1;
    end else if (wr && !in_seq) begin
      tmo_elapsed <= 1'b0;
    end
  end

  // Busy stands while the window runs so the controller holds off.
  always_ff @(posedge bus.pclk or negedge bus.presetn) begin
    if (!bus.presetn) bus.busy <= 1'b0;
    else bus.busy <= tmo_cnt > 13'h0001 || (wr && hit && !in_seq && bus.wdata[7:0] == D_ERASE_BLOCK);
  end

  assign flash_status_byte = {bus.busy, 1'b0, write_error, 1'b0, tmo_elapsed, 3'b000};

  // The strap cannot be loaded under reset, so it is caught on the first
  // clock after release; a low pin means boot from external memory.
  always_ff @(posedge bus.pclk or negedge bus.presetn) begin
    if (!bus.presetn) begin
      strap_done <= 1'b0;
      internal_memory_enable <= 1'b0;
      low_segment_map_select <= 1'b1;
      segmentation_disable <= 1'b1;
    end else if (!strap_done) begin
      strap_done <= 1'b1;
      internal_memory_enable <= external_access_n;
    end else if (bus.cfg_we) begin
      internal_memory_enable <= bus.cfg_wdata[CFG_MEM_EN_BIT];
      low_segment_map_select <= bus.cfg_wdata[CFG_LOWSEG_BIT];
      segmentation_disable <= bus.cfg_wdata[CFG_SEGDIS_BIT];
    end
  end

  // Internal reset lengthening. It goes only to the CPU core; nothing
  // drives the shared reset pin, so the outside never sees it.
  always_ff @(posedge bus.pclk or negedge bus.presetn) begin
    if (!bus.presetn) begin
      rst_cnt <= 3'(RST_EXT_CYC);
      cpu_reset_extend <= 1'b1;
    end else begin
      if (rst_cnt != 3'h0) rst_cnt <= rst_cnt - 3'h1;
      cpu_reset_extend <= rst_cnt > 3'h1;
    end
  end
endmodule : fpci_dev

// ==== src/fpci_host.sv ====
/*
  Controller end: an APB slave whose registers order protection commands,
  which it plays out as CPU cycles on the shared bus.
  Assumes an APB master on pclk; the device answers each request with ack.
*/
module fpci_host
  import fpci_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  fpci_if.cpu bus
);
  typedef enum logic [1:0] {H_IDLE = 2'b00, H_WAIT = 2'b01, H_REQ = 2'b11} fpci_hst_t;
  fpci_hst_t state;
  fpci_cmd_t cmd;
  logic [23:0] addr_reg;
  logic [15:0] data_reg;
  logic [15:0] last_rdata;
  logic [15:0] pr_shadow;
  logic [1:0] step;
  logic [1:0] last_step;
  logic apb_wr;
  logic special;
  fpci_beat_t beat;

  // Builds one CPU cycle of a command; coded cycles keep the page bits.
  function automatic fpci_beat_t make_beat(
    input fpci_cmd_t c,
    input logic [1:0] s,
    input logic [23:0] a,
    input logic [15:0] d,
    input logic [15:0] prs
  );
    fpci_beat_t b;
    b = '{we: 1'b1, addr: {a[23:14], CODED_ADDR_A}, data: {8'h00, D_UNLOCK1}};
    case (s)
      2'd1: b = '{we: 1'b1, addr: {a[23:14], CODED_ADDR_B}, data: {8'h00, D_UNLOCK2}};
      2'd2: begin
        b.data[7:0] = c == CMD_SET_PROT ? D_SET_PROT : c == CMD_READ_PROT ? D_READ_PROT : D_BLK_UNPROT;
      end
      2'd3: begin
        b.addr = {a[23:2], ODD_WORD_LSB};
        b.we = c != CMD_READ_PROT;
        b.data = c == CMD_SET_PROT ? (d & prs) : {8'h00, D_BLK_CONFIRM};
      end
      default: begin
        if (c == CMD_CODE_UNPROT) b = '{we: 1'b1, addr: a, data: D_CODE_UNPROT};
        else if (c == CMD_CODE_PROT) b = '{we: 1'b1, addr: a, data: D_CODE_PROT};
        else if (c == CMD_READ) b = '{we: 1'b0, addr: a, data: d};
        else if (c == CMD_WRITE) b = '{we: 1'b1, addr: a, data: d};
      end
    endcase
    make_beat = b;
  endfunction : make_beat

  // Zero-wait APB slave; unmapped offsets answer with an error.
  assign pready = 1'b1;
  assign apb_wr = psel && penable && pwrite;
  always_comb begin
    prdata = 32'h0000_0000;
    pslverr = 1'b0;
    if (paddr == REG_CTRL) prdata = {29'h0, cmd};
    else if (paddr == REG_ADDR) prdata = {8'h00, addr_reg};
    else if (paddr == REG_DATA) prdata = {16'h0000, data_reg};
    else if (paddr == REG_STATUS) prdata = {last_rdata, pr_shadow[7:0], 6'h00, bus.busy, state != H_IDLE};
    else if (paddr == REG_CFG) prdata = 32'h0000_0000;
    else pslverr = psel && penable;
  end

  // Software registers; a start is ignored while a command runs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd <= CMD_READ;
      addr_reg <= 24'h000000;
      data_reg <= 16'h0000;
    end else if (apb_wr) begin
      if (paddr == REG_CTRL && state == H_IDLE) cmd <= fpci_cmd_t'(pwdata[2:0]);
      else if (paddr == REG_ADDR) addr_reg <= pwdata[23:0];
      else if (paddr == REG_DATA) data_reg <= pwdata[15:0];
    end
  end

  // Configuration writes; segmentation disable is forced off in every write that
  // enables flash, so the whole array stays reachable.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus.cfg_we <= 1'b0;
      bus.cfg_wdata <= 3'b110;
    end else begin
      bus.cfg_we <= apb_wr && paddr == REG_CFG;
      if (apb_wr && paddr == REG_CFG) begin
        bus.cfg_wdata <= pwdata[2:0];
        if (pwdata[CFG_MEM_EN_BIT]) bus.cfg_wdata[CFG_SEGDIS_BIT] <= 1'b0;
      end
    end
  end

  assign special = cmd == CMD_CODE_UNPROT || cmd == CMD_CODE_PROT;
  assign last_step = (cmd == CMD_SET_PROT || cmd == CMD_READ_PROT || cmd == CMD_BLK_UNPROT) ? 2'd3 : 2'd0;
  assign beat = make_beat(cmd, step, addr_reg, data_reg, pr_shadow);
  assign bus.req = state == H_REQ;
  assign bus.we = beat.we;
  assign bus.addr = beat.addr;
  assign bus.wdata = beat.data;
  assign bus.from_flash = special;
  assign bus.absolute_mode = special;
  assign bus.indirect_mode = !special;

  // Command sequencer: waits out device busy, then one request every second cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= H_IDLE;
      step <= 2'd0;
      last_rdata <= 16'h0000;
      pr_shadow <= PR_ERASED;
    end else begin
      case (state)
        H_IDLE: if (apb_wr && paddr == REG_CTRL && pwdata[CTRL_START_BIT]) state <= H_WAIT;
        H_WAIT: if (!bus.busy) state <= H_REQ;
        H_REQ: begin
          if (bus.ack) begin
            if (!beat.we) last_rdata <= bus.rdata;
            if (cmd == CMD_READ_PROT && step == 2'd3) pr_shadow <= bus.rdata;
            if (step == last_step) begin
              state <= H_IDLE;
              step <= 2'd0;
            end else begin
              step <= step + 2'd1;
            end
          end
        end
        default: state <= H_IDLE;
      endcase
    end
  end
endmodule : fpci_host

// ==== src/fpci_if.sv ====
/*
  CPU-side bus between the command-issuing controller and the flash
  protection device. Assumes both ends share pclk and presetn.
*/
interface fpci_if (
  input wire logic pclk,
  input wire logic presetn
);
  logic req;
  logic we;
  logic [23:0] addr;
  logic [15:0] wdata;
  logic from_flash;
  logic absolute_mode;
  logic indirect_mode;
  logic [15:0] rdata;
  logic ack;
  logic busy;
  logic cfg_we;
  logic [2:0] cfg_wdata;
  modport dev (
    input pclk, presetn, req, we, addr, wdata, from_flash, absolute_mode, indirect_mode, cfg_we, cfg_wdata,
    output rdata, ack, busy
  );
  modport cpu (
    input pclk, presetn, rdata, ack, busy,
    output req, we, addr, wdata, from_flash, absolute_mode, indirect_mode, cfg_we, cfg_wdata
  );
endinterface : fpci_if

// ==== src/fpci_pkg.sv ====
/*
  Shared constants and types for the flash protection command interface:
  coded command addresses and data, status bit positions, mapping limits,
  timing counts and the controller's register map.
  Assumes a single 50 MHz clock shared by both ends.
*/
// Functional notes
// - Set protection: three coded writes, then value
// - Bit 15 zero stores code protection
// - Bit N zero protects flash block N
// - Cleared bits stay zero, else write error
// - Read protection status returns register until write
// - FFFFh write from flash lifts code protection
// - FFFBh absolute write from flash restores protection
// - Odd word address means 4n-2
// - Coded address compare ignores A14 and above
// - Erase block window 96 us, status bit 3
// - Software polls until chip erase finished
// - Sequences issued from RAM, not flash
// - Idle gaps never abort a sequence
// - Reads inside a sequence return dummy data
// - Register-indirect addressing, page bits in address
// - External access pin sampled into memory enable
// - Memory enable zero disables flash
// - Low map bit moves only first 32K
// - Software clears segmentation disable for 512K
// - Page pointer low bits give A15 A14
// - Reset lengthening not shown on reset pin
// - Protected flash reads from outside give trap
// - 7FFFh protects code; reset clears temporary unprotect
package fpci_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int ERASE_TMO_NS = 96000;
  localparam int ERASE_TMO_CYC = ERASE_TMO_NS / CLK_PERIOD_NS;
  localparam int RST_EXT_CYC = 4;
  localparam logic [13:0] CODED_ADDR_A = 14'h2a54;
  localparam logic [13:0] CODED_ADDR_B = 14'h15a8;
  localparam logic [7:0] D_UNLOCK1 = 8'ha8;
  localparam logic [7:0] D_UNLOCK2 = 8'h54;
  localparam logic [7:0] D_SET_PROT = 8'hc0;
  localparam logic [7:0] D_READ_PROT = 8'h90;
  localparam logic [7:0] D_BLK_UNPROT = 8'hc1;
  localparam logic [7:0] D_BLK_CONFIRM = 8'hf0;
  localparam logic [7:0] D_ERASE_BLOCK = 8'h30;
  localparam logic [15:0] D_CODE_UNPROT = 16'hffff;
  localparam logic [15:0] D_CODE_PROT = 16'hfffb;
  localparam logic [15:0] TRAP_OPCODE = 16'h009b;
  localparam logic [15:0] PR_ERASED = 16'hffff;
  localparam logic [15:0] DUMMY_DATA = 16'h0000;
  localparam int CODE_PROT_BIT = 15;
  localparam logic [1:0] ODD_WORD_LSB = 2'b10;
  localparam logic [23:0] LOW_BLK_SIZE = 24'h008000;
  localparam logic [23:0] LOW_BLK_SEG1 = 24'h010000;
  localparam logic [23:0] UPPER_LO = 24'h018000;
  localparam logic [23:0] UPPER_HI = 24'h08ffff;
  localparam int FSB_TMO_BIT = 3;
  localparam int FSB_ERR_BIT = 5;
  localparam int FSB_BUSY_BIT = 7;
  localparam int CFG_MEM_EN_BIT = 0;
  localparam int CFG_LOWSEG_BIT = 1;
  localparam int CFG_SEGDIS_BIT = 2;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_CFG = 8'h10;
  localparam int CTRL_START_BIT = 8;
  typedef enum logic [2:0] {
    CMD_SET_PROT = 3'h0, CMD_READ_PROT = 3'h1, CMD_BLK_UNPROT = 3'h2, CMD_CODE_UNPROT = 3'h3,
    CMD_CODE_PROT = 3'h4, CMD_READ = 3'h5, CMD_WRITE = 3'h6
  } fpci_cmd_t;
  typedef struct packed {
    logic we;
    logic [23:0] addr;
    logic [15:0] data;
  } fpci_beat_t;
endpackage : fpci_pkg

// ==== src/fpci_seq.sv ====
/*
  Coded command sequence decoder for the protection commands.
  Assumes wr is a one-cycle pulse per accepted CPU write.
*/
module fpci_seq
  import fpci_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr,
  input wire logic [23:0] addr,
  input wire logic [15:0] wdata,
  output logic set_prot_wr,
  output logic [15:0] set_prot_val,
  output logic blk_unprot,
  output logic read_prot_mode,
  output logic in_seq
);
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_C1 = 3'b001, S_C2 = 3'b011, S_SP4 = 3'b010, S_BTU4 = 3'b110, S_RP = 3'b111
  } fpci_seq_t;
  fpci_seq_t state;
  fpci_seq_t next_state;
  logic at_a;
  logic at_b;
  logic odd_word;

  // Only the low fourteen address bits take part in the compare.
  assign at_a = addr[13:0] == CODED_ADDR_A;
  assign at_b = addr[13:0] == CODED_ADDR_B;
  assign odd_word = addr[1:0] == ODD_WORD_LSB;

  // Next state; there is no timeout, so pauses between cycles are harmless.
  always_comb begin
    next_state = state;
    if (wr) begin
      case (state)
        S_C1: next_state = (at_b && wdata[7:0] == D_UNLOCK2) ? S_C2 : S_IDLE;
        S_C2: begin
          if (at_a && wdata[7:0] == D_SET_PROT) next_state = S_SP4;
          else if (at_a && wdata[7:0] == D_READ_PROT) next_state = S_RP;
          else if (at_a && wdata[7:0] == D_BLK_UNPROT) next_state = S_BTU4;
          else next_state = S_IDLE;
        end
        S_SP4, S_BTU4: next_state = S_IDLE;
        default: next_state = (at_a && wdata[7:0] == D_UNLOCK1) ? S_C1 : S_IDLE;
      endcase
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) state <= S_IDLE;
    else state <= next_state;
  end

  // Fourth-cycle strobes, registered so the device sees a clean pulse.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      set_prot_wr <= 1'b0;
      set_prot_val <= PR_ERASED;
      blk_unprot <= 1'b0;
    end else begin
      set_prot_wr <= wr && state == S_SP4 && odd_word;
      set_prot_val <= wdata;
      blk_unprot <= wr && state == S_BTU4 && wdata[7:0] == D_BLK_CONFIRM;
    end
  end

  assign read_prot_mode = state == S_RP;
  assign in_seq = state == S_C1 || state == S_C2 || state == S_SP4 || state == S_BTU4;
endmodule : fpci_seq

// ==== tb/fpci_asserts.sv ====
/*
  Checker for the shared command bus between controller and device end.
  Assumes the bench feeds it the interface signals on the shared clock.
*/
module fpci_asserts
  import fpci_pkg::*;
#(
  parameter int ERASE_TMO_CYCLES = ERASE_TMO_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic req,
  input wire logic we,
  input wire logic [23:0] addr,
  input wire logic [15:0] wdata,
  input wire logic from_flash,
  input wire logic absolute_mode,
  input wire logic [15:0] rdata,
  input wire logic ack,
  input wire logic busy,
  input wire logic cfg_we,
  input wire logic [2:0] cfg_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic take;
  logic [1:0] stage;
  int busy_cnt;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // A beat is taken at an edge with the request up and no answer yet.
  assign take = req && !ack;

  // Follow the coded prefix, so that reads inside an open sequence are known.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage <= 2'd0;
    end else if (take && we) begin
      if (addr[13:0] == CODED_ADDR_A && wdata[7:0] == D_UNLOCK1)
        stage <= 2'd1;
      else if (stage == 2'd1 && addr[13:0] == CODED_ADDR_B && wdata[7:0] == D_UNLOCK2)
        stage <= 2'd2;
      else if (stage == 2'd2 && addr[13:0] == CODED_ADDR_A && (wdata[7:0] == D_SET_PROT || wdata[7:0] == D_BLK_UNPROT))
        stage <= 2'd3;
      else
        stage <= 2'd0;
    end
  end

  // Length of the erase window; a new write may legally reload it, so restart.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      busy_cnt <= 0;
    else if (!busy || (take && we))
      busy_cnt <= 0;
    else
      busy_cnt <= busy_cnt + 1;
  end

  ack_follows_take_a: assert property (take |=> ack)
    else $error("bus beat not answered in the next cycle");
  ack_single_a: assert property (ack |=> !ack)
    else $error("acknowledge longer than one cycle");
  request_held_a: assert property (take |=> req && $stable(addr) && $stable(wdata) && $stable(we))
    else $error("request changed before its answer");
  read_data_held_a: assert property (!(ack && !we) |-> $stable(rdata))
    else $error("read data changed without a read");
  dummy_read_a: assert property (take && !we && stage == 2'd3 |=> rdata == DUMMY_DATA)
    else $error("read inside a sequence gave array data");
  erase_window_max_a: assert property (busy |-> busy_cnt <= ERASE_TMO_CYCLES + 1)
    else $error("erase window too long");
  erase_window_min_a: assert property ($fell(busy) |-> $past(busy_cnt) >= ERASE_TMO_CYCLES - 2)
    else $error("erase window too short");
  code_protect_mode_a: assert property (take && we && wdata == D_CODE_PROT |-> from_flash && absolute_mode)
    else $error("code protect write not absolute from flash");
  flash_enable_cfg_a: assert property (cfg_we && cfg_wdata[CFG_MEM_EN_BIT] |-> !cfg_wdata[CFG_SEGDIS_BIT])
    else $error("flash enabled with segmentation still disabled");

  cover property (take && !we && stage == 2'd3);
  cover property ($fell(busy));
  cover property (cfg_we && cfg_wdata[CFG_MEM_EN_BIT]);
endmodule : fpci_asserts

// ==== tb/fpci_bench.sv ====
/*
  Bench for the flash protection command interface: APB orders drive the
  controller, which plays commands to the device end across the interface.
  Assumes the array answers combinationally with a fixed word.
*/
module fpci_bench
  import fpci_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TMO = 20;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, err_seen;
  logic external_access_n = 1'b1;
  logic [15:0] array_rdata = 16'h1234;
  logic [15:0] protection_register;
  logic code_protect_active, internal_memory_enable, low_segment_map_select, segmentation_disable;
  logic [14:0] block_protect;
  logic [7:0] flash_status_byte;
  logic cpu_reset_extend;
  int error_cnt = 0;
  int checks = 0;

  // Free-running 50 MHz clock.
  initial forever #10 pclk = ~pclk;

  fpci_if fpci_if_inst (.pclk(pclk), .presetn(presetn));
  fpci_host fpci_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(fpci_if_inst.cpu));
  fpci_dev #(.ERASE_TMO_CYCLES(TMO)) fpci_dev_inst (.bus(fpci_if_inst.dev), .external_access_n(external_access_n),
    .array_addr(), .array_rdata(array_rdata), .protection_register(protection_register),
    .code_protect_active(code_protect_active), .block_protect(block_protect), .flash_status_byte(flash_status_byte),
    .internal_memory_enable(internal_memory_enable), .low_segment_map_select(low_segment_map_select),
    .segmentation_disable(segmentation_disable), .cpu_reset_extend(cpu_reset_extend));
  fpci_asserts #(.ERASE_TMO_CYCLES(TMO)) fpci_asserts_inst (.pclk(pclk), .presetn(presetn),
    .req(fpci_if_inst.req), .we(fpci_if_inst.we), .addr(fpci_if_inst.addr), .wdata(fpci_if_inst.wdata),
    .from_flash(fpci_if_inst.from_flash), .absolute_mode(fpci_if_inst.absolute_mode), .rdata(fpci_if_inst.rdata),
    .ack(fpci_if_inst.ack), .busy(fpci_if_inst.busy), .cfg_we(fpci_if_inst.cfg_we),
    .cfg_wdata(fpci_if_inst.cfg_wdata));

  // Verdict and end of run; every path out comes through here.
  task automatic conclude;
    if (error_cnt == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; answers are read right at the rising edge, before the
  // design's updates land, so they are the values that this edge samples.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    logic rdy;
    n = 0;
    rdy = 1'b0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    while (!rdy) begin
      @(posedge pclk);
      rdy = pready;
      q = prdata;
      err_seen = pslverr;
      n++;
      if (n > 50) begin
        error_cnt++;
        conclude();
      end
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Read status until the chosen bit drops, under a bounded count.
  task automatic poll(input int b);
    int n;
    n = 0;
    q = 32'hffffffff;
    while (q[b] !== 1'b0) begin
      apb(1'b0, REG_STATUS, 32'h0);
      n++;
      if (n > 200) begin
        error_cnt++;
        conclude();
      end
    end
  endtask : poll

  // Load address and data, start a command and wait until it has run.
  task automatic cmd(input logic [2:0] c, input logic [23:0] a, input logic [15:0] d);
    apb(1'b1, REG_ADDR, {8'h00, a});
    apb(1'b1, REG_DATA, {16'h0000, d});
    apb(1'b1, REG_CTRL, {23'h000000, 1'b1, 5'h00, c});
    poll(0);
  endtask : cmd

  // Main sequence; the manual sequence runs while code is unprotected, but its
  // read falls inside the open sequence and gives dummy data instead of the array word.
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(32'(internal_memory_enable), 32'h1);
    chk(32'(low_segment_map_select), 32'h1);
    cmd(3'h1, 24'h000006, 16'h0000);
    chk(32'(q[31:16]), 32'hffff);
    chk(32'(cpu_reset_extend), 32'h0);
    cmd(3'h0, 24'h00c006, 16'h7ffe);
    chk(32'(protection_register), 32'h7ffe);
    chk(32'(code_protect_active), 32'h1);
    chk(32'(block_protect), 32'h1);
    cmd(3'h0, 24'h000002, 16'hffff);
    chk(32'(protection_register), 32'h7ffe);
    chk(32'(flash_status_byte[FSB_ERR_BIT]), 32'h1);
    cmd(3'h1, 24'h000006, 16'h0000);
    chk(32'(q[31:16]), 32'h7ffe);
    cmd(3'h5, 24'h000100, 16'h0000);
    chk(32'(q[31:16]), 32'(TRAP_OPCODE));
    cmd(3'h3, 24'h000100, 16'h0000);
    chk(32'(code_protect_active), 32'h0);
    cmd(3'h5, 24'h000100, 16'h0000);
    chk(32'(q[31:16]), 32'h1234);
    cmd(3'h6, 24'h002a54, 16'h00a8);
    repeat (7) @(posedge pclk);
    cmd(3'h6, 24'h0015a8, 16'h0054);
    cmd(3'h6, 24'h002a54, 16'h00c0);
    cmd(3'h5, 24'h000100, 16'h0000);
    chk(32'(q[31:16]), 32'(DUMMY_DATA));
    cmd(3'h6, 24'h000002, 16'h7ffe);
    chk(32'(flash_status_byte[FSB_ERR_BIT]), 32'h0);
    chk(32'(protection_register), 32'h7ffe);
    cmd(3'h4, 24'h000100, 16'h0000);
    chk(32'(code_protect_active), 32'h1);
    cmd(3'h2, 24'h000100, 16'h0000);
    chk(32'(block_protect), 32'h0);
    cmd(3'h6, 24'h000200, 16'h0030);
    chk(32'(flash_status_byte[FSB_BUSY_BIT]), 32'h1);
    poll(1);
    chk(32'(flash_status_byte[FSB_TMO_BIT]), 32'h1);
    apb(1'b1, 8'h20, 32'h0);
    chk(32'(err_seen), 32'h1);
    apb(1'b1, REG_CFG, 32'h0);
    apb(1'b0, REG_CFG, 32'h0);
    chk(q, 32'h0);
    chk(32'(internal_memory_enable), 32'h0);
    chk(32'(low_segment_map_select), 32'h0);
    apb(1'b1, REG_CFG, 32'h1);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(32'(internal_memory_enable), 32'h1);
    chk(32'(segmentation_disable), 32'h0);
    conclude();
  end
endmodule : fpci_bench
